// ==== rtl/bsr_ctrl.sv ====
// Purpose: Bus state control: reset restart, bus exchange, refresh insertion.
// Assumes: Inputs synchronous to ref_clk; core starts cycles only when ready.
// Notes: Interval select is a plain input pair; no software registers.
//
// Contract
// RULE_01: Six-clock reset restarts at address zero.
// RULE_02: Other master holds request low while needed.
// RULE_03: Acknowledge low after buses are released.
// RULE_04: Grant only at machine cycle boundary.
// RULE_05: Memory/IO cycles three clocks plus waits.
// RULE_06: Selector picks 10/20/40/80 state spacing.
// RULE_07: Reset value gives ten-clock refresh interval.
// RULE_08: No refresh in reset, release, sleep, wait.
// RULE_09: Interval timer runs while bus released.
// RULE_10: Refresh due mid-cycle waits for cycle end.
`timescale 1ns/1ps
module bsr_ctrl (
	// Clock and control
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Reset pin and restart
	input wire logic reset_n_pin,
	output logic restart_q,
	output logic [19:0] restart_addr_q,
	// Bus exchange
	input wire logic alt_master_bus_request_n,
	output logic bus_grant_ack_n,
	output logic bus_release_q,
	// Core machine cycles
	input wire bsr_pkg::bsr_cycle_t cycle_in,
	input wire logic sleep_mode,
	output logic core_ready_q,
	output logic cycle_end_q,
	// Refresh
	input wire logic refresh_interval_sel_hi,
	input wire logic refresh_interval_sel_lo,
	output logic refresh_active_q
);
	import bsr_pkg::*;

	bsr_state_t state_q, state_d;
	logic [2:0] rst_cnt_q;
	logic [1:0] cyc_cnt_q;
	logic [6:0] tmr_q;
	logic pend_q;
	logic ack_n_q;
	logic [1:0] sel;
	logic [6:0] interval;
	logic tmr_wrap, cyc_done, boundary, want_bus, refresh_go, pend_d;

	// Interval decode from selector; reset value of selector gives ten states
	function automatic logic [6:0] interval_of(input logic [1:0] s);
		case (s)
			2'b00: interval_of = INTERVAL_10; // RULE_06
			2'b01: interval_of = INTERVAL_20;
			2'b10: interval_of = INTERVAL_40;
			default: interval_of = INTERVAL_80;
		endcase
	endfunction

	// Selector is forced to its reset value while reset pin is low
	assign sel = reset_n_pin ? {refresh_interval_sel_hi, refresh_interval_sel_lo}
		: REFRESH_SEL_RESET; // RULE_07
	assign interval = interval_of(sel);
	// Wrap at or past the end, so a shorter selection never lets the count run away
	assign tmr_wrap = (tmr_q >= interval - 7'h01);
	// A long cycle ends after three clocks unless a wait state holds it
	assign cyc_done = (state_q == BSR_ST_CYCLE) && !cycle_in.wait_req
		&& (cyc_cnt_q == MEM_CYCLE_MIN_CLKS - 2'h1); // RULE_05
	assign boundary = (state_q == BSR_ST_IDLE) || cyc_done; // RULE_04
	assign want_bus = !alt_master_bus_request_n; // RULE_02
	// Refresh never during reset, release, sleep or waits
	assign refresh_go = (pend_q || tmr_wrap) && boundary && !want_bus
		&& !sleep_mode && !cycle_in.wait_req && reset_n_pin; // RULE_08
	// Due refresh is held until the running cycle finishes
	assign pend_d = (state_q == BSR_ST_RELEASED) ? 1'b0
		: (refresh_go ? 1'b0 : (pend_q || tmr_wrap)); // RULE_10

	// Next state; bus goes away only on a boundary
	always_comb begin
		state_d = state_q;
		case (state_q)
			BSR_ST_IDLE, BSR_ST_CYCLE: begin
				if (state_q == BSR_ST_CYCLE && !cyc_done) begin
					state_d = BSR_ST_CYCLE;
				end else if (want_bus) begin
					state_d = BSR_ST_RELEASED; // RULE_04
				end else if (refresh_go) begin
					state_d = BSR_ST_REFRESH;
				end else if (cycle_in.start && cycle_in.long_cycle) begin
					state_d = BSR_ST_CYCLE;
				end else begin
					state_d = BSR_ST_IDLE;
				end
			end
			BSR_ST_REFRESH: begin
				if (cyc_cnt_q == REFRESH_CLKS - 2'h1) begin
					state_d = BSR_ST_IDLE;
				end
			end
			BSR_ST_RELEASED: begin
				if (!want_bus) begin
					state_d = BSR_ST_IDLE;
				end
			end
			default: state_d = BSR_ST_IDLE;
		endcase
	end

	// Reset pin qualifier: restart only after six low clocks
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rst_cnt_q <= 3'h0;
			restart_q <= 1'b0;
			restart_addr_q <= RESTART_ADDR;
		end else if (clk_en) begin
			if (!reset_n_pin) begin
				if (rst_cnt_q != RESET_MIN_CYCLES) begin
					rst_cnt_q <= rst_cnt_q + 3'h1;
				end
			end else begin
				rst_cnt_q <= 3'h0;
			end
			// Shorter pulses are glitches and are ignored
			restart_q <= reset_n_pin && (rst_cnt_q == RESET_MIN_CYCLES); // RULE_01
			restart_addr_q <= RESTART_ADDR; // RULE_01
		end
	end

	// Refresh timer free-runs, also while the bus is released
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tmr_q <= 7'h00;
			pend_q <= 1'b0;
		end else if (clk_en) begin
			if (!reset_n_pin || tmr_wrap) begin
				tmr_q <= 7'h00;
			end else begin
				tmr_q <= tmr_q + 7'h01; // RULE_09
			end
			pend_q <= reset_n_pin && pend_d;
		end
	end

	// Sequencer, cycle counter and registered outputs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= BSR_ST_IDLE;
			cyc_cnt_q <= 2'h0;
			ack_n_q <= 1'b1;
			bus_release_q <= 1'b0;
			refresh_active_q <= 1'b0;
			core_ready_q <= 1'b0;
			cycle_end_q <= 1'b0;
		end else if (clk_en) begin
			if (!reset_n_pin) begin
				state_q <= BSR_ST_IDLE;
				cyc_cnt_q <= 2'h0;
			end else begin
				state_q <= state_d;
				// A long cycle straight after another restarts the count at its boundary
				if (state_d != state_q || state_q == BSR_ST_IDLE || cyc_done) begin
					cyc_cnt_q <= 2'h0;
				end else if (!cycle_in.wait_req || state_q == BSR_ST_REFRESH) begin
					if (cyc_cnt_q != 2'h3) begin
						cyc_cnt_q <= cyc_cnt_q + 2'h1;
					end
				end
			end
			// Release drives first; acknowledge follows one clock later
			bus_release_q <= reset_n_pin && (state_d == BSR_ST_RELEASED);
			ack_n_q <= !(bus_release_q && reset_n_pin
				&& state_d == BSR_ST_RELEASED); // RULE_03
			refresh_active_q <= reset_n_pin && (state_d == BSR_ST_REFRESH);
			core_ready_q <= reset_n_pin && (state_d == BSR_ST_IDLE);
			cycle_end_q <= reset_n_pin && cyc_done;
		end
	end

	assign bus_grant_ack_n = ack_n_q;

	// Acknowledge only when the bus has been released a clock before
	a_ack_after_release: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(bus_grant_ack_n) |-> $past(bus_release_q)) // RULE_03
		else $error("ack asserted before release");
	// No refresh state while bus is held by the other master
	a_no_refresh_rel: assert property (@(posedge ref_clk) disable iff (reset)
		!(refresh_active_q && !bus_grant_ack_n)) // RULE_08
		else $error("refresh during bus release");
	// Refresh steps; a low enable stretches one and a low reset pin cuts it
	sequence s_refresh_begin;
		$rose(refresh_active_q) && clk_en && reset_n_pin;
	endsequence
	sequence s_refresh_step;
		clk_en && reset_n_pin;
	endsequence
	// Refresh stands for three enabled clocks
	a_refresh_len: assert property (@(posedge ref_clk) disable iff (reset)
		s_refresh_begin ##1 s_refresh_step
		|-> refresh_active_q ##1 refresh_active_q) // RULE_07
		else $error("refresh length wrong");
	// And drops after the third enabled clock
	a_refresh_end: assert property (@(posedge ref_clk) disable iff (reset)
		(refresh_active_q && $past(refresh_active_q) && $past(refresh_active_q, 2)
		&& !$past(refresh_active_q, 3) && clk_en && $past(clk_en) && $past(clk_en, 2))
		|=> !refresh_active_q) // RULE_07
		else $error("refresh too long");
	// Long cycles end no sooner than three clocks after they start
	a_long_cycle_min: assert property (@(posedge ref_clk) disable iff (reset)
		cyc_done |-> $past(state_q) == BSR_ST_CYCLE && $past(state_q, 2) == BSR_ST_CYCLE) // RULE_05
		else $error("long cycle too short");
	// Release begins only from a boundary
	a_grant_boundary: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && state_d == BSR_ST_RELEASED && state_q == BSR_ST_CYCLE)
		|-> cyc_done) // RULE_04
		else $error("grant mid cycle");
	// Timer stays below the longest interval
	a_timer_bound: assert property (@(posedge ref_clk) disable iff (reset)
		tmr_q < INTERVAL_80) // RULE_06
		else $error("timer out of range");
	// Timer keeps counting while released
	a_timer_runs: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && state_q == BSR_ST_RELEASED && reset_n_pin && !tmr_wrap)
		|=> tmr_q == $past(tmr_q) + 7'h01) // RULE_09
		else $error("timer stopped during release");
	// Restart follows a six-clock low reset pulse
	a_restart_cause: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(restart_q) |-> $past(rst_cnt_q) == RESET_MIN_CYCLES) // RULE_01
		else $error("restart without long reset");
	// Pending refresh is not dropped while cycle runs
	a_pend_hold: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && pend_q && state_q == BSR_ST_CYCLE && !cyc_done && reset_n_pin)
		|=> pend_q) // RULE_10
		else $error("pending refresh lost");

endmodule

// ==== rtl/bsr_pkg.sv ====
// Purpose: Shared constants and types for the bus state and refresh control block.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes: Refresh intervals are counted in clock states.
package bsr_pkg;

	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam logic [2:0] RESET_MIN_CYCLES = 3'h6;
	localparam logic [1:0] MEM_CYCLE_MIN_CLKS = 2'h3;
	localparam logic [1:0] REFRESH_CLKS = 2'h3;
	localparam logic [19:0] RESTART_ADDR = 20'h0_0000;
	localparam logic [6:0] INTERVAL_10 = 7'h0A;
	localparam logic [6:0] INTERVAL_20 = 7'h14;
	localparam logic [6:0] INTERVAL_40 = 7'h28;
	localparam logic [6:0] INTERVAL_80 = 7'h50;
	localparam logic [1:0] REFRESH_SEL_RESET = 2'h0;

	typedef enum logic [1:0] {
		BSR_ST_IDLE = 2'b00,
		BSR_ST_CYCLE = 2'b01,
		BSR_ST_REFRESH = 2'b10,
		BSR_ST_RELEASED = 2'b11
	} bsr_state_t;

	// Machine cycle request from the core
	typedef struct packed {
		logic start;
		logic long_cycle;
		logic wait_req;
	} bsr_cycle_t;

endpackage

// ==== sim/bsr_alt_master.sv ====
// Purpose: Alternate bus master model for the bus exchange.
// Assumes: Bench raises want while it needs the bus.
// Notes: Request moves only after a falling edge.
`timescale 1ns/1ps
module bsr_alt_master (
	// Clock
	input wire logic ref_clk,
	// Demand and request pin
	input wire logic want,
	output logic alt_master_bus_request_n
);
	initial alt_master_bus_request_n = 1'b1;
	// Hold the request low for as long as the bus is wanted
	always @(negedge ref_clk) begin
		alt_master_bus_request_n <= !want;
	end
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for bus state and refresh control.
// Assumes: Inputs change at the falling edge; one 40 MHz clock.
// Notes: Reset check and selector rows first, then hand tests.
`timescale 1ns/1ps
module testbench;
	import bsr_pkg::*;
	logic ref_clk = 0, reset = 1, clk_en = 1, reset_n_pin = 1, sleep_mode = 0, want = 0;
	logic [1:0] sel = 2'h0;
	bsr_cycle_t cyc = '0;
	logic req_n, ack_n, rel_q, rst_q, rdy_q, end_q, ref_q;
	logic [19:0] addr_q;
	int miscompares = 0, num_checks = 0, g, d, n, m;
	int rows [4][2] = '{'{0, INTERVAL_10}, '{1, INTERVAL_20},
		'{2, INTERVAL_40}, '{3, INTERVAL_80}};

	always #12.5 ref_clk = ~ref_clk;

	bsr_alt_master partner (.ref_clk(ref_clk), .want(want), .alt_master_bus_request_n(req_n));
	bsr_ctrl uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reset_n_pin(reset_n_pin),
		.restart_q(rst_q), .restart_addr_q(addr_q), .alt_master_bus_request_n(req_n),
		.bus_grant_ack_n(ack_n), .bus_release_q(rel_q), .cycle_in(cyc), .sleep_mode(sleep_mode),
		.core_ready_q(rdy_q), .cycle_end_q(end_q), .refresh_interval_sel_hi(sel[1]),
		.refresh_interval_sel_lo(sel[0]), .refresh_active_q(ref_q));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Count refresh clocks in n and restart pulses in m over a span
	task automatic quiet(input int len);
		n = 0;
		m = 0;
		repeat (len) begin
			@(negedge ref_clk);
			n += (ref_q === 1'b1);
			m += (rst_q === 1'b1);
		end
	endtask

	// Length of one refresh and the rise-to-rise spacing; bounded waits
	task automatic meas(output int gap, output int dur);
		int k;
		k = 0;
		while (ref_q !== 1'b1 && k < 300) begin
			@(negedge ref_clk);
			k++;
		end
		dur = 0;
		while (ref_q === 1'b1 && dur < 300) begin
			@(negedge ref_clk);
			dur++;
		end
		gap = dur;
		while (ref_q !== 1'b1 && gap < 300) begin
			@(negedge ref_clk);
			gap++;
		end
	endtask

	initial begin
		repeat (12) @(negedge ref_clk);
		// Outputs sit at their idle levels while reset is held
		check(ack_n, 1);
		check(rel_q, 0);
		check(ref_q, 0);
		check(rst_q, 0);
		$display("test reset done");
		reset = 0;
		// First measure may start mid-pulse, so the second one counts
		meas(g, d);
		meas(g, d);
		check(g, 10);
		check(d, REFRESH_CLKS);
		foreach (rows[i]) begin
			sel = 2'(rows[i][0]);
			meas(g, d);
			meas(g, d);
			check(g, rows[i][1]);
			$display("test sel %0d done", i);
		end
		sel = 2'h0;
		sleep_mode = 1;
		// The refresh that has just begun runs to its end first
		quiet(4);
		quiet(50);
		check(n, 0);
		sleep_mode = 0;
		$display("test sleep done");
		// One clock short of the minimum span is ignored
		reset_n_pin = 0;
		quiet(RESET_MIN_CYCLES - 1);
		reset_n_pin = 1;
		quiet(3);
		check(m, 0);
		// Minimum reset pin span, then one restart at address zero
		reset_n_pin = 0;
		quiet(RESET_MIN_CYCLES);
		check(n, 0);
		reset_n_pin = 1;
		quiet(3);
		check(m, 1);
		check(addr_q, RESTART_ADDR);
		$display("test reset pin done");
		// Request arrives inside a long cycle stretched by two waits
		n = 0;
		while (!(rdy_q === 1'b1 && ref_q !== 1'b1) && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		cyc.start = 1;
		cyc.long_cycle = 1;
		d = 0;
		while (rdy_q === 1'b1 && d < 20) begin
			@(negedge ref_clk);
			d++;
		end
		cyc.start = 0;
		cyc.wait_req = 1;
		want <= 1;
		quiet(2);
		check(n, 0);
		cyc.wait_req = 0;
		d = 3;
		while (end_q !== 1'b1 && d < 20) begin
			check(ack_n, 1);
			@(negedge ref_clk);
			d++;
		end
		// Counted from the edge before start: three clocks, two waits, one lead
		check(d, MEM_CYCLE_MIN_CLKS + 3);
		n = 0;
		while (ack_n !== 1'b0 && n < 5) begin
			@(negedge ref_clk);
			n++;
		end
		check(rel_q, 1);
		check(ack_n, 0);
		quiet(40);
		check(n, 0);
		want <= 0;
		quiet(4);
		check(ack_n, 1);
		check(rel_q, 0);
		$display("test bus exchange done");
		// A refresh due inside a stretched cycle waits for the cycle end
		meas(g, d);
		quiet(3);
		check(rdy_q, 1);
		cyc = '{start: 1'b1, long_cycle: 1'b1, wait_req: 1'b1};
		quiet(1);
		check(rdy_q, 0);
		cyc.start = 0;
		quiet(7);
		check(n, 0);
		cyc.wait_req = 0;
		d = 0;
		while (end_q !== 1'b1 && d < 20) begin
			@(negedge ref_clk);
			d++;
		end
		check(d, MEM_CYCLE_MIN_CLKS);
		check(ref_q, 1);
		$display("test pending refresh done");
		// Low enable freezes the running refresh, which then completes
		clk_en = 0;
		quiet(30);
		check(n, 30);
		clk_en = 1;
		quiet(4);
		check(n, REFRESH_CLKS - 1);
		$display("test clock enable done");
		stop_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#(CLK_PERIOD_NS * 20000);
		miscompares++;
		stop_test();
	end
endmodule
